// ### ftis_pkg.sv
package ftis_pkg;
    // Register byte addresses (index * 4 truncated to 8 bits, so indices 64 to 67 wrap to offsets 0 to 12)
    localparam int unsigned IDX_CTRL_A   = 13;
    localparam int unsigned IDX_CTRL_B   = 14;
    localparam int unsigned IDX_THRESH   = 15;
    localparam int unsigned IDX_MODE     = 64;
    localparam int unsigned IDX_FIFOCFG  = 65;
    localparam int unsigned IDX_STATUS   = 66;
    localparam int unsigned IDX_MASK     = 67;
    localparam logic [7:0]  ADDR_CTRL_A  = 8'(IDX_CTRL_A * 4);
    localparam logic [7:0]  ADDR_CTRL_B  = 8'(IDX_CTRL_B * 4);
    localparam logic [7:0]  ADDR_THRESH  = 8'(IDX_THRESH * 4);
    localparam logic [7:0]  ADDR_MODE    = 8'(IDX_MODE * 4);
    localparam logic [7:0]  ADDR_FIFOCFG = 8'(IDX_FIFOCFG * 4);
    localparam logic [7:0]  ADDR_STATUS  = 8'(IDX_STATUS * 4);
    localparam logic [7:0]  ADDR_MASK    = 8'(IDX_MASK * 4);
    // Control byte B fields
    localparam int unsigned B_FILL_SEL   = 7;
    localparam int unsigned B_FILL_CTL   = 6;
    localparam int unsigned B_TX_DONE    = 5;
    localparam int unsigned B_TX_START   = 4;
    localparam int unsigned B_SIG_EN     = 3;
    localparam int unsigned B_SIG_FLAG   = 2;
    localparam int unsigned B_LOCK_FLAG  = 1;
    localparam int unsigned B_LOCK_EN    = 0;
    // Control byte A: overrun flag
    localparam int unsigned A_OVERRUN    = 0;
    // Reset values
    localparam logic [7:0]  CTRL_B_RST   = 8'h01;
    localparam logic [7:0]  THRESH_RST   = 8'h00;
    localparam logic [1:0]  MODE_RST     = 2'h0;
    // Interrupt status bit layout
    localparam int unsigned NUM_EVT      = 4;
    localparam int unsigned E_TX_DONE    = 0;
    localparam int unsigned E_SIG        = 1;
    localparam int unsigned E_LOCK       = 2;
    localparam int unsigned E_OVERRUN    = 3;
    localparam logic [1:0]  RESP_OKAY    = 2'b00;
    localparam logic [1:0]  RESP_SLVERR  = 2'b10;
    typedef enum logic [1:0] {
        DM_CONT   = 2'b00,
        DM_BUFF   = 2'b01,
        DM_PACK0  = 2'b10,
        DM_PACK1  = 2'b11
    } ftis_mode_t;
endpackage : ftis_pkg

// ### ftis_axil.sv
`timescale 1ns/1ns
`default_nettype none
// AXI4-Lite slave front end: one write and one read in flight
module ftis_axil (
    // System
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // AXI4-Lite
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output var  logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output var  logic        wready,
    output var  logic [1:0]  bresp,
    output var  logic        bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output var  logic        arready,
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        rvalid,
    input  wire logic        rready,
    // Register side
    output var  logic        wrStb,
    output var  logic [7:0]  wrAddr,
    output var  logic [7:0]  wrByte,
    output var  logic        rdStb,
    output var  logic [7:0]  rdAddr,
    input  wire logic [7:0]  rdByte,
    input  wire logic        rdHit,
    input  wire logic        wrHit
);
    logic       awHave_q;
    logic       wHave_q;
    logic [7:0] awAddr_q;
    logic [7:0] wByte_q;
    logic       wLane_q;
    logic       rdPend_q;

    // Readies are flops so every top-level output leaves a register
    assign wrStb   = awHave_q && wHave_q && !bvalid;
    assign wrAddr  = awAddr_q;
    // Only byte lane 0 carries data; other lanes are ignored
    assign wrByte  = wLane_q ? wByte_q : 8'h00;
    assign rdStb   = arvalid && arready;
    assign rdAddr  = araddr;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            awHave_q <= 1'b0;
            wHave_q  <= 1'b0;
            awAddr_q <= 8'h00;
            wByte_q  <= 8'h00;
            wLane_q  <= 1'b0;
            awready  <= 1'b1;
            wready   <= 1'b1;
            bvalid   <= 1'b0;
            bresp    <= ftis_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awHave_q <= 1'b1;
                awAddr_q <= awaddr;
                awready  <= 1'b0;
            end
            if (wvalid && wready) begin
                wHave_q <= 1'b1;
                wByte_q <= wdata[7:0];
                wLane_q <= wstrb[0];
                wready  <= 1'b0;
            end
            if (wrStb) begin
                awHave_q <= 1'b0;
                wHave_q  <= 1'b0;
                bvalid   <= 1'b1;
                bresp    <= wrHit ? ftis_pkg::RESP_OKAY : ftis_pkg::RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdPend_q <= 1'b0;
            arready  <= 1'b1;
            rvalid   <= 1'b0;
            rdata    <= 32'h0000_0000;
            rresp    <= ftis_pkg::RESP_OKAY;
        end else begin
            rdPend_q <= rdStb;
            if (rdStb) begin
                arready <= 1'b0;
            end
            if (rdPend_q) begin
                rvalid <= 1'b1;
                rdata  <= {24'h00_0000, rdByte};
                rresp  <= rdHit ? ftis_pkg::RESP_OKAY : ftis_pkg::RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end
endmodule // ftis_axil
`default_nettype wire

// ### ftis_ctrl.sv
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module ftis_ctrl #(
    parameter int unsigned CNT_W = 7
) (
    // System
    input  wire logic             clock,
    input  wire logic             sys_rst,
    // AXI4-Lite
    input  wire logic [7:0]       awaddr,
    input  wire logic             awvalid,
    output var  logic             awready,
    input  wire logic [31:0]      wdata,
    input  wire logic [3:0]       wstrb,
    input  wire logic             wvalid,
    output var  logic             wready,
    output var  logic [1:0]       bresp,
    output var  logic             bvalid,
    input  wire logic             bready,
    input  wire logic [7:0]       araddr,
    input  wire logic             arvalid,
    output var  logic             arready,
    output var  logic [31:0]      rdata,
    output var  logic [1:0]       rresp,
    output var  logic             rvalid,
    input  wire logic             rready,
    // Datapath status
    input  wire logic             syncDetect,
    input  wire logic             fifoFull,
    input  wire logic             fifoEmpty,
    input  wire logic [CNT_W-1:0] fifoCount,
    input  wire logic [CNT_W-1:0] fifoThreshold,
    input  wire logic             overrunEvent,
    input  wire logic             txLastBit,
    input  wire logic [7:0]       rssiValue,
    input  wire logic             synthLocked,
    // Datapath control
    output logic                  fifoFillEn_q,
    output logic                  fifoClear_q,
    output logic                  txStart_q,
    output logic                  irq0_q,
    // Lock pin, enable low while driving
    output logic                  lockPinOut_q,
    output logic                  lockPinOe_n_q,
    // Interrupt
    output logic                  irq_q
);
    logic        wrStb;
    logic [7:0]  wrAddr;
    logic [7:0]  wrByte;
    logic        rdStb;
    logic [7:0]  rdAddr;
    logic [7:0]  rdByte_d;
    logic        rdHit_d;
    logic        wrHit_d;
    logic [7:0]  ctrlB_q;
    logic [7:0]  thresh_q;
    logic [1:0]  mode_q;
    logic        txStartCfg_q;
    logic        overrun_q;
    logic        filling_q;
    logic        txDone_q;
    logic        sigFlag_q;
    logic        lockFlag_q;
    logic [ftis_pkg::NUM_EVT-1:0] evtStat_q;
    logic [ftis_pkg::NUM_EVT-1:0] evtMask_q;
    logic [ftis_pkg::NUM_EVT-1:0] evtSet;
    logic        isBuff;
    logic        isPack;
    logic        autoFill;
    logic        lockEn;
    logic        sigEn;
    logic        rdStatHold_q;

    function automatic logic wr1(input logic [7:0] a, input int unsigned b);
        return wrStb && (wrAddr == a) && wrByte[b];
    endfunction

    ftis_axil u_axil (
        .clock   (clock),
        .sys_rst (sys_rst),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wrStb   (wrStb),
        .wrAddr  (wrAddr),
        .wrByte  (wrByte),
        .rdStb   (rdStb),
        .rdAddr  (rdAddr),
        .rdByte  (rdByte_d),
        .rdHit   (rdHit_d),
        .wrHit   (wrHit_d)
    );

    assign isBuff   = (mode_q == ftis_pkg::DM_BUFF);
    assign isPack   = mode_q[1];
    assign autoFill = !ctrlB_q[ftis_pkg::B_FILL_SEL];
    assign lockEn   = ctrlB_q[ftis_pkg::B_LOCK_EN];
    assign sigEn    = ctrlB_q[ftis_pkg::B_SIG_EN];

    ////////////////////////////////////////////////////////////////////////////
    // Plain configuration registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrlB_q      <= ftis_pkg::CTRL_B_RST;
            thresh_q     <= ftis_pkg::THRESH_RST;
            mode_q       <= ftis_pkg::MODE_RST;
            evtMask_q    <= '0;
        end else if (wrStb) begin
            case (wrAddr)
                ftis_pkg::ADDR_CTRL_B: begin
                    ctrlB_q <= {wrByte[7], 1'b0, 1'b0, wrByte[4], wrByte[3], 2'b00, wrByte[0]};
                end
                ftis_pkg::ADDR_THRESH:  thresh_q  <= wrByte;
                ftis_pkg::ADDR_MODE:    mode_q    <= wrByte[1:0];
                ftis_pkg::ADDR_MASK:    evtMask_q <= wrByte[ftis_pkg::NUM_EVT-1:0];
                default:                mode_q    <= mode_q;
            endcase
        end
    end
    assign txStartCfg_q = ctrlB_q[ftis_pkg::B_TX_START];

    ////////////////////////////////////////////////////////////////////////////
    // FIFO fill control
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            filling_q <= 1'b0;
        end else if (autoFill) begin
            if (wr1(ftis_pkg::ADDR_CTRL_B, ftis_pkg::B_FILL_CTL) && !overrun_q) begin
                filling_q <= 1'b0;
            end else if (syncDetect && isBuff) begin
                filling_q <= 1'b1;
            end
        end else if (wrStb && wrAddr == ftis_pkg::ADDR_CTRL_B && isBuff) begin
            filling_q <= wrByte[ftis_pkg::B_FILL_CTL];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            fifoFillEn_q <= 1'b0;
        end else begin
            fifoFillEn_q <= filling_q && isBuff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags; a set in the clearing cycle wins
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            overrun_q  <= 1'b0;
            txDone_q   <= 1'b0;
            sigFlag_q  <= 1'b0;
            lockFlag_q <= 1'b0;
        end else begin
            if (overrunEvent) begin
                overrun_q <= 1'b1;
            end else if (wr1(ftis_pkg::ADDR_CTRL_A, ftis_pkg::A_OVERRUN)) begin
                overrun_q <= 1'b0;
            end
            if (txLastBit) begin
                txDone_q <= 1'b1;
            end else if (wr1(ftis_pkg::ADDR_CTRL_B, ftis_pkg::B_TX_DONE)) begin
                txDone_q <= 1'b0;
            end
            if (sigEn && rssiValue > thresh_q) begin
                sigFlag_q <= 1'b1;
            end else if (wr1(ftis_pkg::ADDR_CTRL_B, ftis_pkg::B_SIG_FLAG)) begin
                sigFlag_q <= 1'b0;
            end
            if (lockEn && synthLocked) begin
                lockFlag_q <= 1'b1;
            end else if (wr1(ftis_pkg::ADDR_CTRL_B, ftis_pkg::B_LOCK_FLAG)) begin
                lockFlag_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            fifoClear_q <= 1'b0;
        end else begin
            fifoClear_q <= wr1(ftis_pkg::ADDR_CTRL_A, ftis_pkg::A_OVERRUN);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit start and IRQ_0 mapping
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            txStart_q <= 1'b0;
            irq0_q    <= 1'b0;
        end else if (txStartCfg_q && (isBuff || isPack)) begin
            txStart_q <= !fifoEmpty;
            irq0_q    <= !fifoEmpty;
        end else if (isPack) begin
            txStart_q <= fifoCount >= fifoThreshold;
            irq0_q    <= fifoCount >= fifoThreshold;
        end else if (isBuff) begin
            txStart_q <= fifoFull;
            irq0_q    <= !fifoEmpty;
        end else begin
            txStart_q <= 1'b0;
            irq0_q    <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            lockPinOut_q  <= 1'b0;
            lockPinOe_n_q <= 1'b1;
        end else begin
            lockPinOut_q  <= lockEn && synthLocked;
            lockPinOe_n_q <= !lockEn;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, cleared as the bus block captures it, set wins
    assign evtSet = {overrunEvent, lockEn && synthLocked,
                     sigEn && rssiValue > thresh_q, txLastBit};
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            evtStat_q <= '0;
            irq_q     <= 1'b0;
        end else begin
            if (rdStatHold_q) begin
                evtStat_q <= evtSet;
            end else begin
                evtStat_q <= evtStat_q | evtSet;
            end
            irq_q <= |(evtStat_q & evtMask_q);
        end
    end

    // Read mux, captured by the bus block one cycle after the address
    logic [7:0] rdAddrHold_q;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdAddrHold_q <= 8'h00;
            rdStatHold_q <= 1'b0;
        end else begin
            rdAddrHold_q <= rdAddr;
            rdStatHold_q <= rdStb && (rdAddr == ftis_pkg::ADDR_STATUS);
        end
    end

    always_comb begin
        rdByte_d = 8'h00;
        rdHit_d  = 1'b1;
        case (rdAddrHold_q)
            ftis_pkg::ADDR_CTRL_A:  rdByte_d = {7'h00, overrun_q};
            ftis_pkg::ADDR_CTRL_B:  rdByte_d = {ctrlB_q[7], filling_q, txDone_q,
                                                ctrlB_q[4:3], sigFlag_q, lockFlag_q, ctrlB_q[0]};
            ftis_pkg::ADDR_THRESH:  rdByte_d = thresh_q;
            ftis_pkg::ADDR_MODE:    rdByte_d = {6'h00, mode_q};
            ftis_pkg::ADDR_FIFOCFG: rdByte_d = {6'h00, txStart_q, fifoFillEn_q};
            ftis_pkg::ADDR_STATUS:  rdByte_d = {4'h0, evtStat_q};
            ftis_pkg::ADDR_MASK:    rdByte_d = {4'h0, evtMask_q};
            default:                rdHit_d  = 1'b0;
        endcase
    end

    always_comb begin
        case (wrAddr)
            ftis_pkg::ADDR_CTRL_A, ftis_pkg::ADDR_CTRL_B, ftis_pkg::ADDR_THRESH,
            ftis_pkg::ADDR_MODE, ftis_pkg::ADDR_MASK: wrHit_d = 1'b1;
            default:                                  wrHit_d = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // sync sets fill
    chk_sync_sets_fill: assert property (@(posedge clock) disable iff (sys_rst)
        autoFill && isBuff && syncDetect && !wrStb |=> filling_q)
        else $error("fill not set after sync");
    chk_rearm_clears: assert property (@(posedge clock) disable iff (sys_rst)
        autoFill && wrStb && wrAddr == ftis_pkg::ADDR_CTRL_B && wrByte[ftis_pkg::B_FILL_CTL]
        && !overrun_q |=> !filling_q)
        else $error("rearm did not clear fill");
    chk_tx_done_set: assert property (@(posedge clock) disable iff (sys_rst)
        txLastBit |=> txDone_q)
        else $error("tx done missing");
    chk_buff_start: assert property (@(posedge clock) disable iff (sys_rst)
        isBuff && !txStartCfg_q && $stable(mode_q) |=> txStart_q == $past(fifoFull))
        else $error("buffered start wrong");
    chk_ne_start: assert property (@(posedge clock) disable iff (sys_rst)
        mode_q != ftis_pkg::DM_CONT && txStartCfg_q |=> txStart_q == $past(!fifoEmpty))
        else $error("not-empty start wrong");
    chk_sig_flag: assert property (@(posedge clock) disable iff (sys_rst)
        sigEn && rssiValue > thresh_q |=> sigFlag_q)
        else $error("signal flag not set");
    chk_lock_pin: assert property (@(posedge clock) disable iff (sys_rst)
        !lockEn ##1 !lockEn |-> lockPinOe_n_q)
        else $error("lock pin driven while disabled");
    chk_overrun_clr: assert property (@(posedge clock) disable iff (sys_rst)
        wrStb && wrAddr == ftis_pkg::ADDR_CTRL_A && wrByte[ftis_pkg::A_OVERRUN]
        |=> fifoClear_q ##1 !fifoClear_q[*1])
        else $error("fifo clear pulse wrong");
    chk_flag_hold: assert property (@(posedge clock) disable iff (sys_rst)
        sigFlag_q && !(wrStb && wrAddr == ftis_pkg::ADDR_CTRL_B && wrByte[ftis_pkg::B_SIG_FLAG])
        |=> sigFlag_q)
        else $error("signal flag dropped");

    cov_auto_fill: cover property (@(posedge clock) disable iff (sys_rst)
        autoFill && isBuff && syncDetect ##1 filling_q);
    cov_pack_start: cover property (@(posedge clock) disable iff (sys_rst)
        isPack && !txStartCfg_q ##1 txStart_q);
    cov_irq_out: cover property (@(posedge clock) disable iff (sys_rst) irq_q);
endmodule // ftis_ctrl
`default_nettype wire

// ### ftis_fifo_model.sv
`timescale 1ns/1ns
`default_nettype none
// FIFO side of the block; level flags are derived from one count
module ftis_fifo_model #(
    parameter int unsigned DEPTH = 64,
    parameter int unsigned CNT_W = 7
) (
    // Fill level asked for
    input  wire logic [CNT_W-1:0] level,
    // Status toward the block
    output logic [CNT_W-1:0]      fifoCount,
    output logic                  fifoEmpty,
    output logic                  fifoFull
);
    assign fifoCount = level;
    assign fifoEmpty = (level == '0);
    assign fifoFull  = (level == CNT_W'(DEPTH));
endmodule // ftis_fifo_model
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clock = 0, sys_rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, rssiValue = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 4'hF;
    logic syncDetect = 0, overrunEvent = 0, txLastBit = 0, synthLocked = 0;
    logic [6:0] level = 0, fifoThreshold = 0, fifoCount;
    logic awready, wready, bvalid, arready, rvalid, fifoEmpty, fifoFull;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic fifoFillEn_q, fifoClear_q, txStart_q, irq0_q, lockPinOut_q, lockPinOe_n_q, irq_q;
    logic [17:0] notes[$];
    logic [1:0] wnotes[$];
    int nErrors = 0, checked = 0, nClr = 0, cyc = 0, seed = 36;
    logic [6:0] thr;
    logic exT, exI, ne, ge;

    ftis_ctrl #(.CNT_W(7)) dut (.clock, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .syncDetect, .fifoFull, .fifoEmpty, .fifoCount,
        .fifoThreshold, .overrunEvent, .txLastBit, .rssiValue, .synthLocked, .fifoFillEn_q,
        .fifoClear_q, .txStart_q, .irq0_q, .lockPinOut_q, .lockPinOe_n_q, .irq_q);
    ftis_fifo_model #(.DEPTH(64), .CNT_W(7)) fifo (.level, .fifoCount, .fifoEmpty, .fifoFull);

    initial forever #5 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finalReport();
        $display("comparisons %0d mismatches %0d", checked, nErrors);
        if (nErrors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [9:0] s, input logic [9:0] e);
        checked++;
        if (s !== e) begin
            nErrors++;
            $display("wrong value at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] r = ftis_pkg::RESP_OKAY);
        logic da, dw, ta, tw, tb_;
        da = 0; dw = 0; tb_ = 0;
        @(posedge clock);
        awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
        wnotes.push_back(r);
        while (!(da && dw)) begin
            @(negedge clock); ta = awready; tw = wready;
            @(posedge clock);
            if (ta && !da) begin awvalid <= 0; da = 1; end
            if (tw && !dw) begin wvalid <= 0; dw = 1; end
        end
        while (!tb_) begin @(negedge clock); tb_ = bvalid; @(posedge clock); end
        bready <= 0;
    endtask
    // Read with a note of {mask, resp, data} for the watcher
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m = 8'hFF,
                      input logic [1:0] r = ftis_pkg::RESP_OKAY);
        logic t;
        t = 0;
        @(posedge clock);
        araddr <= a; arvalid <= 1; rready <= 1; notes.push_back({m, r, d});
        while (!t) begin @(negedge clock); t = arready; @(posedge clock); end
        arvalid <= 0; t = 0;
        while (!t) begin @(negedge clock); t = rvalid; @(posedge clock); end
        rready <= 0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge clock) if (rvalid && rready) begin
        logic [17:0] n;
        n = notes.pop_front();
        check({rresp, rdata[7:0] & n[17:10]}, n[9:0]);
        check(10'(rdata[31:8] != 0), 10'(0));
    end
    always @(negedge clock) if (bvalid && bready) begin
        check(10'(bresp), 10'(wnotes.pop_front()));
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (fifoClear_q) nClr <= nClr + 1;
        // Long enough for every test, with wide margin
        if (cyc == 30000) begin nErrors++; finalReport(); end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clock);
        sys_rst <= 0;
        rd(ftis_pkg::ADDR_CTRL_B, 8'h01);
        rd(ftis_pkg::ADDR_THRESH, 8'h00);
        check(10'(lockPinOe_n_q), 10'(0));
        $display("reset values done");
        rd(ftis_pkg::ADDR_STATUS, 8'h00);
        wr(ftis_pkg::ADDR_MASK, 8'h01);
        @(posedge clock) txLastBit <= 1; @(posedge clock) txLastBit <= 0; idle(3);
        check(10'(irq_q), 10'(1));
        rd(ftis_pkg::ADDR_STATUS, 8'h01); idle(2);
        check(10'(irq_q), 10'(0));
        wr(ftis_pkg::ADDR_MASK, 8'h00);
        @(posedge clock) txLastBit <= 1; @(posedge clock) txLastBit <= 0; idle(3);
        check(10'(irq_q), 10'(0));
        rd(ftis_pkg::ADDR_CTRL_B, 8'h21); wr(ftis_pkg::ADDR_CTRL_B, 8'h21);
        rd(ftis_pkg::ADDR_CTRL_B, 8'h01);
        $display("transmit done and interrupt done");
        thr = 7'($random(seed)); wr(ftis_pkg::ADDR_THRESH, {1'b0, thr});
        rd(ftis_pkg::ADDR_THRESH, {1'b0, thr});
        // Host enables the level source
        wr(ftis_pkg::ADDR_CTRL_B, 8'h09);
        @(posedge clock) rssiValue <= {1'b0, thr}; idle(3);
        rd(ftis_pkg::ADDR_CTRL_B, 8'h09);
        @(posedge clock) rssiValue <= {1'b0, thr} + 8'h01; idle(3);
        @(posedge clock) rssiValue <= 0;
        rd(ftis_pkg::ADDR_CTRL_B, 8'h0D); wr(ftis_pkg::ADDR_CTRL_B, 8'h0D);
        rd(ftis_pkg::ADDR_CTRL_B, 8'h09);
        $display("signal level done");
        @(posedge clock) synthLocked <= 1; idle(3);
        check(10'({lockPinOut_q, lockPinOe_n_q}), 10'(2));
        @(posedge clock) synthLocked <= 0;
        rd(ftis_pkg::ADDR_CTRL_B, 8'h0B); wr(ftis_pkg::ADDR_CTRL_B, 8'h0B);
        rd(ftis_pkg::ADDR_CTRL_B, 8'h09);
        wr(ftis_pkg::ADDR_CTRL_B, 8'h08); @(posedge clock) synthLocked <= 1; idle(3);
        check(10'(lockPinOe_n_q), 10'(1));
        rd(ftis_pkg::ADDR_CTRL_B, 8'h08);
        @(posedge clock) synthLocked <= 0; wr(ftis_pkg::ADDR_CTRL_B, 8'h09);
        $display("lock done");
        @(posedge clock) overrunEvent <= 1; @(posedge clock) overrunEvent <= 0;
        rd(ftis_pkg::ADDR_CTRL_A, 8'h01, 8'h01); wr(ftis_pkg::ADDR_CTRL_A, 8'h01);
        rd(ftis_pkg::ADDR_CTRL_A, 8'h00, 8'h01);
        check(10'(nClr), 10'(1));
        $display("overrun done");
        wr(ftis_pkg::ADDR_MODE, 8'h01);
        @(posedge clock) syncDetect <= 1; @(posedge clock) syncDetect <= 0; idle(3);
        check(10'(fifoFillEn_q), 10'(1));
        // No re-arm while an overrun is pending
        @(posedge clock) overrunEvent <= 1; @(posedge clock) overrunEvent <= 0;
        wr(ftis_pkg::ADDR_CTRL_B, 8'h49); idle(2);
        check(10'(fifoFillEn_q), 10'(1));
        wr(ftis_pkg::ADDR_CTRL_A, 8'h01);
        rd(ftis_pkg::ADDR_CTRL_B, 8'h49); wr(ftis_pkg::ADDR_CTRL_B, 8'h49); idle(2);
        check(10'(fifoFillEn_q), 10'(0));
        // Manual mode first, then the start write
        wr(ftis_pkg::ADDR_CTRL_B, 8'h89); wr(ftis_pkg::ADDR_CTRL_B, 8'hC9); idle(2);
        check(10'(fifoFillEn_q), 10'(1));
        wr(ftis_pkg::ADDR_CTRL_B, 8'h89); idle(2);
        check(10'(fifoFillEn_q), 10'(0));
        $display("fill control done");
        for (int m = 0; m < 4; m++) for (int s = 0; s < 2; s++) for (int c = 0; c < 3; c++) begin
            wr(ftis_pkg::ADDR_MODE, 8'(m)); wr(ftis_pkg::ADDR_CTRL_B, 8'h01 | 8'(s << 4));
            @(posedge clock);
            level <= (c == 0) ? 7'd0 : (c == 1) ? 7'd64 : 7'(1 + $unsigned($random(seed)) % 63);
            fifoThreshold <= 7'($unsigned($random(seed)) % 64); idle(3);
            ne = (level != 0); ge = (level >= fifoThreshold);
            exT = (m == 0) ? 0 : s ? ne : (m == 1) ? (level == 64) : ge;
            exI = (m == 0) ? 0 : (m >= 2 && s == 0) ? ge : ne;
            check(10'({txStart_q, irq0_q}), 10'({exT, exI}));
        end
        $display("start conditions done");
        rd(8'h80, 8'h00, 8'hFF, ftis_pkg::RESP_SLVERR);
        wr(8'h80, 8'h00, ftis_pkg::RESP_SLVERR);
        $display("unmapped access done");
        idle(4);
        finalReport();
    end
endmodule // tb
`default_nettype wire
